/* hw/oda_cfg.svh */
// Constants for the operand descriptor address decoder
`ifndef ODA_CFG_SVH
`define ODA_CFG_SVH

`define ODA_DATA_W      32
`define ODA_LEN_W       3
// Addressing-method numbers held in the upper descriptor nibble
`define ODA_M_WIMM      4'h4
`define ODA_M_HIMM      4'h5
`define ODA_M_FPSO      4'h6
`define ODA_M_APSO      4'h7
`define ODA_M_WDISP     4'h8
`define ODA_M_WDISPD    4'h9
`define ODA_M_HDISP     4'hA
`define ODA_M_HDISPD    4'hB
`define ODA_M_BDISP     4'hC
`define ODA_M_BDISPD    4'hD
`define ODA_M_ABSD      4'hE
`define ODA_M_NLIT      4'hF
// Register-field values with special meaning
`define ODA_R_EXCL      4'hB
`define ODA_R_IMM       4'hF
// Descriptor field positions
`define ODA_MODE_HI     7
`define ODA_MODE_LO     4
`define ODA_REG_HI      3
`define ODA_LIT_HI      5
// Extension byte counts and total operand lengths
`define ODA_EXT_0       3'h0
`define ODA_EXT_1       3'h1
`define ODA_EXT_2       3'h2
`define ODA_EXT_4       3'h4
`define ODA_LEN_1       3'h1
`define ODA_LEN_2       3'h2
`define ODA_LEN_3       3'h3
`define ODA_LEN_5       3'h5

`endif

/* hw/oda_pkg.sv */
// Types shared by the operand descriptor address decoder
`include "oda_cfg.svh"
package oda_pkg;

    typedef enum logic [2:0] {
        ODA_IDLE, ODA_DESC, ODA_EXT, ODA_CALC, ODA_PTR, ODA_LOAD
    } oda_state_t;

    typedef enum logic [2:0] {
        ODA_K_LIT, ODA_K_IMM, ODA_K_DISP, ODA_K_DISPD, ODA_K_SO, ODA_K_UNSUP
    } oda_kind_t;

    typedef struct packed {
        oda_state_t                 st;
        logic [7:0]                 desc;
        logic [`ODA_DATA_W-1:0]     ext;
        logic [2:0]                 cnt;
        logic [2:0]                 need;
        logic                       is_dest;
        logic                       takes_ea;
        logic                       ld_ubyte;
        logic                       rdy;
        logic [3:0]                 reg_sel;
        logic                       mem_req;
        logic [`ODA_DATA_W-1:0]     mem_addr;
        logic                       done;
        logic                       is_addr;
        logic [`ODA_DATA_W-1:0]     addr;
        logic [`ODA_DATA_W-1:0]     data;
        logic [`ODA_LEN_W-1:0]      len;
        logic                       illegal;
        logic                       unsup;
        logic                       busy;
    } oda_state_regs_t;

endpackage

/* hw/oda_operand_decoder.sv */
// Operand descriptor decoder: forms operand addresses and immediate data
`timescale 1ns/1ps
`include "oda_cfg.svh"
// Notes on behaviour
// - Descriptor: method upper nibble, register lower
// - Method 12, not reg 11: two bytes
// - Byte displacement sign-extended plus register
// - Method 13: byte displacement forms pointer address
// - Method 10: halfword displacement, three bytes
// - Method 11: halfword displacement forms pointer
// - Method 8: word displacement, five bytes
// - Method 9: word displacement forms pointer
// - Displacement bases never register 11
// - Deferred: fetched word is operand address
// - Multi-byte fields assembled low byte first
// - Method 7 short offset plus argument pointer
// - Method 6 short offset plus frame pointer
// - Method 6 reg 15: signed byte immediate
// - Method 5 reg 15: signed half immediate
// - Method 4 reg 15: signed word immediate
// - Immediate length from method, not opcode
// - Immediate as destination or address: illegal
// - Methods 0-3: unsigned literal 0 to 63
// - Literal is low six bits, zero-filled
// - Unsigned memory byte zero-extended to 32
module oda_operand_decoder
    import oda_pkg::*;
#(
    parameter int DATA_W = `ODA_DATA_W
) (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire logic                  start,
    input  wire logic                  start_is_dest,
    input  wire logic                  start_takes_ea,
    input  wire logic                  start_load_ubyte,
    input  wire logic                  byte_valid,
    input  wire logic [7:0]            byte_data,
    output logic                       byte_ready,
    output logic [3:0]                 reg_sel,
    input  wire logic [DATA_W-1:0]     reg_data,
    input  wire logic [DATA_W-1:0]     argument_pointer,
    input  wire logic [DATA_W-1:0]     frame_pointer,
    output logic                       mem_req,
    output logic [DATA_W-1:0]          mem_addr,
    input  wire logic                  mem_ack,
    input  wire logic [DATA_W-1:0]     mem_data,
    output logic                       busy,
    output logic                       op_done,
    output logic                       op_is_addr,
    output logic [DATA_W-1:0]          op_addr,
    output logic [DATA_W-1:0]          op_data,
    output logic [`ODA_LEN_W-1:0]      op_len,
    output logic                       op_illegal,
    output logic                       op_unsupported
);

    oda_state_regs_t r_r;
    oda_state_regs_t r_nxt;

    // Method and register fields of a descriptor
    function automatic logic [3:0] mode_of(input logic [7:0] d);
        mode_of = d[`ODA_MODE_HI:`ODA_MODE_LO];
    endfunction

    function automatic logic [3:0] regf_of(input logic [7:0] d);
        regf_of = d[`ODA_REG_HI:0];
    endfunction

    // Classify a descriptor; out-of-scope modes fall to unsupported
    function automatic oda_kind_t kind_of(input logic [7:0] d);
        logic [3:0] m;
        logic [3:0] rf;
        m  = mode_of(d);
        rf = regf_of(d);
        kind_of = ODA_K_UNSUP;
        if (m < `ODA_M_WIMM) begin
            kind_of = ODA_K_LIT;
        // Register 15 makes methods 4 to 6 immediates
        end else if (rf == `ODA_R_IMM && m <= `ODA_M_FPSO) begin
            kind_of = ODA_K_IMM;
        // Register 15 keeps displacement bases valid; method 7 with register 15 is unsupported
        end else if ((m == `ODA_M_FPSO || m == `ODA_M_APSO) && rf != `ODA_R_IMM) begin
            kind_of = ODA_K_SO;
        // Register 11 is never a displacement base
        end else if (rf != `ODA_R_EXCL && m >= `ODA_M_WDISP && m <= `ODA_M_BDISPD) begin
            kind_of = m[0] ? ODA_K_DISPD : ODA_K_DISP;
        end
    endfunction

    // Extension bytes after the descriptor, by method and register field
    function automatic logic [2:0] ext_count(input logic [7:0] d);
        logic [3:0] m;
        m = mode_of(d);
        ext_count = `ODA_EXT_0;
        case (kind_of(d))
            // Immediate width ignores the opcode size
            ODA_K_IMM: begin
                if (m == `ODA_M_FPSO) begin
                    ext_count = `ODA_EXT_1;
                end else if (m == `ODA_M_HIMM) begin
                    ext_count = `ODA_EXT_2;
                end else begin
                    ext_count = `ODA_EXT_4;
                end
            end
            ODA_K_DISP, ODA_K_DISPD: begin
                if (m == `ODA_M_BDISP || m == `ODA_M_BDISPD) begin
                    ext_count = `ODA_EXT_1;
                end else if (m == `ODA_M_HDISP || m == `ODA_M_HDISPD) begin
                    ext_count = `ODA_EXT_2;
                end else begin
                    ext_count = `ODA_EXT_4;
                end
            end
            default: ext_count = `ODA_EXT_0;
        endcase
    endfunction

    // Sign extension of a collected field of n bytes
    function automatic logic [DATA_W-1:0] sext(input logic [DATA_W-1:0] v,
                                               input logic [2:0] n);
        if (n == `ODA_EXT_1) begin
            sext = {{(DATA_W-8){v[7]}}, v[7:0]};
        end else if (n == `ODA_EXT_2) begin
            sext = {{(DATA_W-16){v[15]}}, v[15:0]};
        end else begin
            sext = v;
        end
    endfunction

    // Next-state logic for the whole decoder
    always_comb begin
        oda_kind_t           k;
        logic [DATA_W-1:0]   sum;
        logic                fin_addr;
        k        = kind_of(r_r.desc);
        sum      = '0;
        fin_addr = 1'b0;
        r_nxt         = r_r;
        r_nxt.done    = 1'b0;
        r_nxt.illegal = 1'b0;
        r_nxt.unsup   = 1'b0;
        case (r_r.st)
            ODA_IDLE: begin
                if (start) begin
                    r_nxt.is_dest  = start_is_dest;
                    r_nxt.takes_ea = start_takes_ea;
                    r_nxt.ld_ubyte = start_load_ubyte;
                    r_nxt.st       = ODA_DESC;
                end
            end
            ODA_DESC: begin
                if (byte_valid) begin
                    r_nxt.desc    = byte_data;
                    r_nxt.reg_sel = regf_of(byte_data);
                    r_nxt.ext     = '0;
                    r_nxt.cnt     = 3'h0;
                    r_nxt.need    = ext_count(byte_data);
                    r_nxt.st      = (ext_count(byte_data) == `ODA_EXT_0) ? ODA_CALC
                                                                         : ODA_EXT;
                end
            end
            ODA_EXT: begin
                if (byte_valid) begin
                    r_nxt.ext[{r_r.cnt[1:0], 3'h0} +: 8] = byte_data;
                    r_nxt.cnt = r_r.cnt + 3'h1;
                    // Stop exactly at the operand's last byte
                    if (r_r.cnt + 3'h1 == r_r.need) begin
                        r_nxt.st = ODA_CALC;
                    end
                end
            end
            ODA_CALC: begin
                // Length is descriptor plus extension bytes
                r_nxt.len     = r_r.need + 3'h1;
                r_nxt.is_addr = 1'b0;
                r_nxt.data    = '0;
                r_nxt.addr    = '0;
                case (k)
                    ODA_K_LIT: begin
                        // Low six bits, upper bits zero
                        r_nxt.data    = {{(DATA_W-6){1'b0}}, r_r.desc[`ODA_LIT_HI:0]};
                        // Literal cannot be written or addressed
                        r_nxt.illegal = r_r.is_dest | r_r.takes_ea;
                        r_nxt.done    = 1'b1;
                        r_nxt.st      = ODA_IDLE;
                    end
                    ODA_K_IMM: begin
                        // Signed immediate of its own width
                        r_nxt.data    = sext(r_r.ext, r_r.need);
                        // Immediate cannot be written or addressed
                        r_nxt.illegal = r_r.is_dest | r_r.takes_ea;
                        r_nxt.done    = 1'b1;
                        r_nxt.st      = ODA_IDLE;
                    end
                    ODA_K_DISP: begin
                        sum        = reg_data + sext(r_r.ext, r_r.need);
                        r_nxt.addr = sum;
                        fin_addr   = 1'b1;
                    end
                    ODA_K_DISPD: begin
                        sum            = reg_data + sext(r_r.ext, r_r.need);
                        r_nxt.mem_req  = 1'b1;
                        r_nxt.mem_addr = sum;
                        r_nxt.st       = ODA_PTR;
                    end
                    ODA_K_SO: begin
                        // Short offset added to a frame register
                        if (mode_of(r_r.desc) == `ODA_M_APSO) begin
                            sum = argument_pointer + {{(DATA_W-4){1'b0}}, r_r.reg_sel};
                        end else begin
                            sum = frame_pointer + {{(DATA_W-4){1'b0}}, r_r.reg_sel};
                        end
                        r_nxt.addr = sum;
                        fin_addr   = 1'b1;
                    end
                    default: begin
                        // Out-of-scope mode: reported, length left as collected
                        r_nxt.unsup = 1'b1;
                        r_nxt.done  = 1'b1;
                        r_nxt.st    = ODA_IDLE;
                    end
                endcase
            end
            ODA_PTR: begin
                // Pointer word becomes the operand address
                if (mem_ack) begin
                    r_nxt.mem_req = 1'b0;
                    r_nxt.addr    = mem_data;
                    fin_addr      = 1'b1;
                end
            end
            ODA_LOAD: begin
                // Unsigned byte zero-extended to the full word
                if (mem_ack) begin
                    r_nxt.mem_req = 1'b0;
                    r_nxt.data    = {{(DATA_W-8){1'b0}}, mem_data[7:0]};
                    r_nxt.done    = 1'b1;
                    r_nxt.st      = ODA_IDLE;
                end
            end
            default: begin
                r_nxt.st = ODA_IDLE;
            end
        endcase
        // Address ready: either hand it out or fetch the byte it names
        if (fin_addr) begin
            r_nxt.is_addr = 1'b1;
            if (r_r.ld_ubyte) begin
                r_nxt.mem_req  = 1'b1;
                r_nxt.mem_addr = r_nxt.addr;
                r_nxt.st       = ODA_LOAD;
            end else begin
                r_nxt.done = 1'b1;
                r_nxt.st   = ODA_IDLE;
            end
        end
        // Ready follows state so no byte past the operand is taken
        r_nxt.rdy  = (r_nxt.st == ODA_DESC) || (r_nxt.st == ODA_EXT);
        r_nxt.busy = (r_nxt.st != ODA_IDLE);
    end

    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // All outputs straight from the state register
    assign byte_ready     = r_r.rdy;
    assign reg_sel        = r_r.reg_sel;
    assign mem_req        = r_r.mem_req;
    assign mem_addr       = r_r.mem_addr;
    assign busy           = r_r.busy;
    assign op_done        = r_r.done;
    assign op_is_addr     = r_r.is_addr;
    assign op_addr        = r_r.addr;
    assign op_data        = r_r.data;
    assign op_len         = r_r.len;
    assign op_illegal     = r_r.illegal;
    assign op_unsupported = r_r.unsup;

    // Checks on the decoder's own outputs
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_len_bdisp: assert property (
        op_done && !op_unsupported && mode_of(r_r.desc) == `ODA_M_BDISP
        |-> op_len == `ODA_LEN_2 && op_is_addr)
        else $error("byte displacement length not two");

    chk_len_hdisp: assert property (
        op_done && !op_unsupported && mode_of(r_r.desc) == `ODA_M_HDISP
        |-> op_len == `ODA_LEN_3)
        else $error("halfword displacement length not three");

    chk_len_wdisp: assert property (
        op_done && !op_unsupported && mode_of(r_r.desc) == `ODA_M_WDISP
        |-> op_len == `ODA_LEN_5)
        else $error("word displacement length not five");

    chk_no_reg11: assert property (
        op_done && op_is_addr && mode_of(r_r.desc) >= `ODA_M_WDISP
        |-> regf_of(r_r.desc) != `ODA_R_EXCL)
        else $error("register 11 used as displacement base");

    chk_lit_value: assert property (
        op_done && mode_of(r_r.desc) < `ODA_M_WIMM
        |-> op_data == {{(DATA_W-6){1'b0}}, r_r.desc[`ODA_LIT_HI:0]} && op_len == `ODA_LEN_1)
        else $error("literal value or length wrong");

    chk_imm_illegal: assert property (
        op_done && (kind_of(r_r.desc) == ODA_K_IMM || kind_of(r_r.desc) == ODA_K_LIT)
        |-> op_illegal == (r_r.is_dest | r_r.takes_ea))
        else $error("illegal-operand flag wrong for immediate");

    chk_ptr_addr: assert property (
        r_r.st == ODA_PTR && mem_ack && !r_r.ld_ubyte
        |=> op_done && op_addr == $past(mem_data))
        else $error("pointer word not used as address");

    chk_ubyte_zext: assert property (
        r_r.st == ODA_LOAD && mem_ack
        |=> op_done && op_data[DATA_W-1:8] == '0 && op_data[7:0] == $past(mem_data[7:0]))
        else $error("loaded byte not zero-extended");

    chk_ready_drop: assert property (
        r_r.st == ODA_EXT && byte_valid && byte_ready && r_r.cnt + 3'h1 == r_r.need
        |=> !byte_ready ##1 !byte_ready)
        else $error("byte taken past operand end");

endmodule // oda_operand_decoder

/* test/oda_far_model.sv */
// Far-side model: register file, pointer registers and memory read port
`timescale 1ns/1ps
module oda_far_model (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [3:0]  reg_sel,
    output logic [31:0]      reg_data,
    output logic [31:0]      argument_pointer,
    output logic [31:0]      frame_pointer,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    output logic             mem_ack,
    output logic [31:0]      mem_data
);
    integer     seed = 38;
    logic [1:0] wait_r;

    // Each register holds a value tied to its number
    function automatic logic [31:0] reg_word(input logic [3:0] n);
        return {4'h1, n, 24'h000100};
    endfunction

    // Memory scrambled from the address, so no storage is needed
    function automatic logic [31:0] mem_word(input logic [31:0] a);
        return {a[15:0], a[31:16]} ^ 32'h5A5AA5A5;
    endfunction

    // Register file reads settle in the same cycle
    assign reg_data         = reg_word(reg_sel);
    assign argument_pointer = 32'h00008000;
    assign frame_pointer    = 32'h0000C000;

    // Answer after 0 to 3 idle cycles; data toggles off the answer cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack  <= 1'b0;
            mem_data <= 32'h00000000;
            wait_r   <= 2'h0;
        end else if (mem_ack) begin
            mem_ack  <= 1'b0;
            mem_data <= ~mem_data;
            wait_r   <= 2'($random(seed));
        end else if (mem_req && wait_r == 2'h0) begin
            mem_ack  <= 1'b1;
            mem_data <= mem_word(mem_addr);
        end else begin
            mem_data <= ~mem_data;
            if (mem_req) wait_r <= wait_r - 2'h1;
        end
    end
endmodule // oda_far_model

/* test/tb_operand_descriptor_address_decoder.sv */
// Self-checking bench for the operand descriptor decoder
`timescale 1ns/1ps
`include "oda_cfg.svh"
module tb_operand_descriptor_address_decoder;
    typedef struct packed {
        logic [`ODA_LEN_W-1:0] len;
        logic                  illegal;
        logic                  unsup;
        logic                  is_addr;
        logic                  chk_data;
        logic [31:0]           addr;
        logic [31:0]           data;
    } oda_exp_t;

    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        start = 1'b0, start_is_dest = 1'b0, start_takes_ea = 1'b0;
    logic        start_load_ubyte = 1'b0, byte_valid = 1'b0;
    logic [7:0]  byte_data = 8'h00;
    logic        byte_ready, mem_req, mem_ack, busy, op_done, op_is_addr;
    logic        op_illegal, op_unsupported;
    logic [3:0]  reg_sel;
    logic [31:0] reg_data, argument_pointer, frame_pointer, mem_addr, mem_data;
    logic [31:0] op_addr, op_data, r;
    logic [`ODA_LEN_W-1:0] op_len;
    int          err_count = 0;
    int          total_checks = 0;
    integer      seed = 38;
    oda_exp_t    exp_q[$];
    oda_exp_t    got;

    // Free-running 100 MHz clock
    always #5 clock = ~clock;

    oda_operand_decoder oda_operand_decoder_inst (
        .clock(clock), .rst_n(rst_n), .start(start), .start_is_dest(start_is_dest),
        .start_takes_ea(start_takes_ea), .start_load_ubyte(start_load_ubyte),
        .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
        .reg_sel(reg_sel), .reg_data(reg_data), .argument_pointer(argument_pointer),
        .frame_pointer(frame_pointer), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_data(mem_data), .busy(busy), .op_done(op_done),
        .op_is_addr(op_is_addr), .op_addr(op_addr), .op_data(op_data), .op_len(op_len),
        .op_illegal(op_illegal), .op_unsupported(op_unsupported));

    oda_far_model oda_far_model_inst (
        .clock(clock), .rst_n(rst_n), .reg_sel(reg_sel), .reg_data(reg_data),
        .argument_pointer(argument_pointer), .frame_pointer(frame_pointer),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data));

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask

    // Reference decode of one operand; extension bytes come low first in x
    function automatic oda_exp_t predict(input logic [7:0] d, input logic [31:0] x,
                                         input logic dst, input logic ea, input logic ub);
        oda_exp_t    e;
        logic [3:0]  m;
        logic [31:0] a;
        m = d[7:4];
        e = '0;
        e.len = 3'h1;
        e.unsup = 1'b1;
        if (m <= 4'h3) begin
            e = '{3'h1, dst | ea, 1'b0, 1'b0, 1'b1, 32'h0, {26'h0, d[5:0]}};
        end else if (d[3:0] == 4'hF && m <= 4'h6) begin
            e.unsup = 1'b0;
            e.illegal = dst | ea;
            e.chk_data = 1'b1;
            e.len = (m == 4'h4) ? 3'h5 : (m == 4'h5) ? 3'h3 : 3'h2;
            e.data = (m == 4'h4) ? x : (m == 4'h5) ? {{16{x[15]}}, x[15:0]} :
                     {{24{x[7]}}, x[7:0]};
        end else if (m == 4'h6 || m == 4'h7) begin
            e.unsup = (d[3:0] == 4'hF);
            a = ((m == 4'h7) ? argument_pointer : frame_pointer) + {28'h0, d[3:0]};
            e.is_addr = !e.unsup;
        end else if (m >= 4'h8 && m <= 4'hD && d[3:0] != 4'hB) begin
            e.unsup = 1'b0;
            e.is_addr = 1'b1;
            e.len = (m >= 4'hC) ? 3'h2 : (m >= 4'hA) ? 3'h3 : 3'h5;
            a = (m >= 4'hC) ? {{24{x[7]}}, x[7:0]} : (m >= 4'hA) ? {{16{x[15]}}, x[15:0]} : x;
            a = oda_far_model_inst.reg_word(d[3:0]) + a;
            if (m[0]) a = oda_far_model_inst.mem_word(a);
        end
        if (e.is_addr) begin
            e.addr = a;
            e.chk_data = ub;
            a = oda_far_model_inst.mem_word(a);
            e.data = {24'h0, a[7:0]};
        end
        return e;
    endfunction

    // Send one operand; pk pulses start again while busy, which must be ignored
    task automatic op(input logic [7:0] d, input logic [31:0] x, input logic dst,
                      input logic ea, input logic ub, input logic pk);
        oda_exp_t e;
        int       i;
        e = predict(d, x, dst, ea, ub);
        exp_q.push_back(e);
        i = 0;
        start <= 1'b1;
        {start_is_dest, start_takes_ea, start_load_ubyte} <= {dst, ea, ub};
        @(posedge clock);
        start <= 1'b0;
        byte_valid <= 1'b1;
        byte_data <= d;
        while (i < e.len) begin
            @(posedge clock);
            if (byte_ready === 1'b1) begin
                i++;
                byte_data <= (i < e.len) ? x[8*(i-1) +: 8] : ~byte_data;
                byte_valid <= (i < e.len);
            end
            start <= pk && i == 1;
        end
        @(posedge clock);
        start <= 1'b0;
        for (i = 0; i < 100; i++) begin
            @(posedge clock);
            if (busy === 1'b0) break;
        end
        if (i == 100) check(32'h1, 32'h0);
    endtask

    // Each result pulse consumes the oldest expectation
    always @(posedge clock) begin
        if (op_done === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                got = exp_q.pop_front();
                check({29'h0, op_len}, {29'h0, got.len});
                check({31'h0, op_illegal}, {31'h0, got.illegal});
                check({31'h0, op_unsupported}, {31'h0, got.unsup});
                if (!got.unsup) check({31'h0, op_is_addr}, {31'h0, got.is_addr});
                if (got.is_addr) check(op_addr, got.addr);
                if (got.chk_data) check(op_data, got.data);
            end
        end
    end

    // Directed table first, then random descriptors
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        op(8'hC1, 32'h06, 0, 0, 0, 0);
        op(8'hC2, 32'hF0, 0, 0, 0, 1);
        op(8'hD2, 32'h30, 0, 0, 1, 0);
        op(8'hA2, 32'h1101, 0, 0, 0, 0);
        op(8'hB2, 32'h8000, 0, 0, 0, 0);
        op(8'h82, 32'h00112234, 0, 0, 1, 0);
        op(8'h92, 32'h20304050, 0, 0, 1, 0);
        op(8'hCB, 32'h0, 0, 0, 0, 0);
        op(8'hAB, 32'h0, 0, 0, 0, 0);
        op(8'h8B, 32'h0, 0, 0, 0, 0);
        op(8'h7E, 32'h0, 0, 0, 1, 0);
        op(8'h60, 32'h0, 0, 0, 0, 0);
        op(8'h6F, 32'h80, 0, 0, 0, 0);
        op(8'h5F, 32'h8034, 0, 0, 0, 0);
        op(8'h4F, 32'h12345678, 0, 0, 0, 0);
        op(8'h6F, 32'h28, 1, 0, 0, 0);
        op(8'h3F, 32'h0, 0, 1, 1, 1);
        repeat (60) begin
            r = $random(seed);
            op(r[7:0], $random(seed), r[10:8] == 3'h0, r[13:11] == 3'h0, r[14], r[15]);
        end
        repeat (5) @(posedge clock);
        check(32'(exp_q.size()), 32'h0);
        wrap_up();
    end

    // Cuts a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        wrap_up();
    end
endmodule // tb_operand_descriptor_address_decoder
